// *** pkg/fsc_params.svh ***
// Field positions, reset values and timing counts of the status and timer block.
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
`define FSC_CLK_PERIOD_NS 5
`define FSC_MS_NS 1000000
`define FSC_MS_CYCLES (`FSC_MS_NS / `FSC_CLK_PERIOD_NS)
`define FSC_SLOW_FACTOR 2
`define FSC_UNLOAD_STEP_SHIFT 4
`define FSC_SETTLE_STEP_SHIFT 1
`define FSC_STEP_CODE_SPAN 5'h10
`define FSC_RECAL_MAX_STEPS 7'h4d
`define FSC_ST0_INVALID 8'h80
`define FSC_ST0_RESET 8'h00
`define FSC_TC_NORMAL 2'h0
`define FSC_TC_FAILED 2'h1
`define FSC_TC_INVALID 2'h2
`define FSC_TC_READY_CHG 2'h3
`define FSC_ST0_SE_BIT 5
`define FSC_ST0_EC_BIT 4
`define FSC_ST0_NR_BIT 3
`define FSC_ST0_HD_BIT 2
`endif

// *** pkg/fsc_pkg.sv ***
// Types shared by the status and timer block.
package fsc_pkg;
    typedef enum logic [2:0] {
        OP_SPECIFY = 3'h0,
        OP_SENSE_INT = 3'h1,
        OP_SENSE_DRIVE = 3'h2,
        OP_SEEK = 3'h3,
        OP_RECAL = 3'h4,
        OP_RW = 3'h5,
        OP_INVALID = 3'h6
    } fsc_op_type;

    typedef struct packed {
        fsc_op_type op;
        logic [1:0] drive;
        logic head;
        logic [7:0] arg1;
        logic [7:0] arg2;
    } fsc_cmd_type;

    typedef struct packed {
        logic drive_fault;
        logic write_prot;
        logic ready;
        logic track_zero_line;
        logic two_sided_line;
    } fsc_lines_type;

    typedef struct packed {
        logic [1:0] termination_code;
        logic equipment_check;
        logic end_of_cylinder;
        logic crc_error;
        logic overrun;
        logic non_dma_select_or_sector_missing;
        logic write_protected_hit;
        logic missing_mark;
        logic deleted_mark_seen;
        logic data_field_crc_error;
        logic wrong_cylinder;
        logic scan_equal_hit;
        logic scan_unsatisfied;
        logic bad_cylinder;
        logic missing_data_mark;
    } fsc_exec_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EXEC = 4'h2,
        ST_RECAL = 4'h4,
        ST_RESULT = 4'h8
    } fsc_state_type;
endpackage : fsc_pkg

// *** core/fsc_timer.sv ***
// Down-counting interval timer in millisecond ticks.
`timescale 1ns/1ps
module fsc_timer #(
    parameter int W = 9
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic ms_tick,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic busy,
    output logic done
);
    logic [W-1:0] count;
    wire logic last_tick = busy && ms_tick && (count <= {{(W-1){1'b0}}, 1'b1});

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            done <= last_tick;
            if (start) begin
                count <= load;
                busy <= 1'b1;
            end else if (last_tick) begin
                count <= '0;
                busy <= 1'b0;
            end else if (busy && ms_tick) begin
                count <= count - 1'b1;
            end
        end
    end

    // A zero load would never count; it finishes on the next tick instead.
    a_timer_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && start) |=> busy && count == $past(load))
        else $error("timer did not load its interval");
endmodule : fsc_timer

// *** core/fsc_core.sv ***
// Status reporting, interrupt cause tracking and drive timers of the disk controller.
`timescale 1ns/1ps
`include "fsc_params.svh"
module fsc_core #(
    parameter int MS_CYCLES = `FSC_MS_CYCLES,
    parameter int PRE_W = 20
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic slow_clock_mode,
    input wire logic cmd_strobe,
    input wire fsc_pkg::fsc_cmd_type cmd,
    input wire logic result_read,
    input wire fsc_pkg::fsc_lines_type drive_lines,
    input wire logic [3:0] ready_lines,
    input wire logic step_pulse,
    input wire logic seek_end,
    input wire logic seek_abnormal,
    input wire logic exec_done,
    input wire fsc_pkg::fsc_exec_type exec_status,
    input wire logic xfer_byte,
    input wire logic xfer_ack,
    input wire logic head_load_rise,
    output logic int_out,
    output logic transfer_direction,
    output logic request_for_master,
    output logic non_dma_mode,
    output logic [7:0] command_status_zero,
    output logic [7:0] command_status_one,
    output logic [7:0] command_status_two,
    output logic [7:0] drive_line_status,
    output logic [1:0] sel_drive,
    output logic sel_head,
    output logic step_ready,
    output logic head_unload_due,
    output logic head_settled
);
    function automatic logic [7:0] mk_st0(input logic [1:0] tc, input logic se, input logic ec,
                                          input logic nr, input logic hd, input logic [1:0] drv);
        mk_st0 = {tc, se, ec, nr, hd, drv};
    endfunction : mk_st0

    function automatic logic [1:0] first_set(input logic [3:0] v);
        first_set = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
    endfunction : first_set

    fsc_pkg::fsc_state_type state;
    fsc_pkg::fsc_state_type next_state;
    logic [PRE_W-1:0] pre_count;
    logic [3:0] ready_prev;
    logic [3:0] step_code;
    logic [3:0] unload_code;
    logic [6:0] settle_code;
    logic pend_seek;
    logic pend_ready;
    logic [7:0] seek_st0;
    logic [7:0] ready_st0;
    logic [6:0] recal_steps;
    logic ready_lost;
    logic ready_armed;
    logic [2:0] tmr_start;
    logic [8:0] tmr_load [3];
    logic [2:0] tmr_busy;
    logic [2:0] tmr_done;

    // Rescaling the prescaler keeps every interval in step with the device clock rate.
    wire logic [PRE_W-1:0] pre_limit = slow_clock_mode ? PRE_W'(MS_CYCLES * `FSC_SLOW_FACTOR - 1)
                                                       : PRE_W'(MS_CYCLES - 1);
    // A mode change can leave the count above the shorter limit, so it wraps on reaching or passing it.
    wire logic ms_tick = (pre_count >= pre_limit);
    wire logic idle = (state == fsc_pkg::ST_IDLE);
    wire logic take = cmd_strobe && idle;
    wire logic [3:0] ready_chg = ready_lines ^ ready_prev;
    // Changes count only once a real sample is held, so reset is not taken for a toggle.
    wire logic ready_evt = ready_armed && (|ready_chg);
    wire logic blocked = pend_seek && (cmd.op != fsc_pkg::OP_SENSE_INT);
    wire logic bad_cmd = take && ((cmd.op == fsc_pkg::OP_INVALID) || blocked);
    wire logic ok_cmd = take && !bad_cmd;
    wire logic do_sense = ok_cmd && (cmd.op == fsc_pkg::OP_SENSE_INT);
    wire logic do_drive = ok_cmd && (cmd.op == fsc_pkg::OP_SENSE_DRIVE);
    wire logic do_spec = ok_cmd && (cmd.op == fsc_pkg::OP_SPECIFY);
    wire logic do_seek = ok_cmd && (cmd.op == fsc_pkg::OP_SEEK);
    wire logic do_recal = ok_cmd && (cmd.op == fsc_pkg::OP_RECAL);
    wire logic do_rw = ok_cmd && (cmd.op == fsc_pkg::OP_RW);
    wire logic rw_nr = !drive_lines.ready || (cmd.head && !drive_lines.two_sided_line);
    wire logic rw_refused = do_rw && rw_nr;
    wire logic in_recal = (state == fsc_pkg::ST_RECAL);
    wire logic recal_ok = in_recal && drive_lines.track_zero_line && drive_lines.ready;
    wire logic recal_limit = in_recal && step_pulse && !drive_lines.track_zero_line
                             && (recal_steps == `FSC_RECAL_MAX_STEPS - 7'h1);
    wire logic recal_bad = in_recal && !recal_ok && (drive_lines.drive_fault
                           || !drive_lines.ready || recal_limit);
    wire logic recal_fin = recal_ok || recal_bad;
    wire logic seek_evt = seek_end || recal_fin;
    wire logic seek_bad = recal_fin ? recal_bad : seek_abnormal;
    wire logic seek_ec = drive_lines.drive_fault || (recal_fin && recal_limit);
    // Cause codes: ok ends give normal termination, failures give the failed code.
    wire logic [7:0] seek_word = mk_st0(seek_bad ? `FSC_TC_FAILED : `FSC_TC_NORMAL, 1'b1,
                                        seek_ec, !drive_lines.ready,
                                        sel_head, sel_drive);
    wire logic [7:0] ready_word = mk_st0(`FSC_TC_READY_CHG, 1'b0, 1'b0, 1'b0, 1'b0,
                                         first_set(ready_chg));
    wire logic [7:0] sense_word = pend_seek ? seek_st0 : pend_ready ? ready_st0
                                                         : `FSC_ST0_INVALID;
    wire logic in_exec = (state == fsc_pkg::ST_EXEC);
    wire logic rw_end = in_exec && exec_done;
    wire logic [1:0] rw_tc = (ready_lost || ready_evt) ? `FSC_TC_READY_CHG
                             : exec_status.termination_code;
    wire logic [7:0] rw_st0 = mk_st0(rw_tc, 1'b0, exec_status.equipment_check, 1'b0,
                                     sel_head, sel_drive);
    wire fsc_pkg::fsc_exec_type es = exec_status;
    wire logic [7:0] rw_st1 = {es.end_of_cylinder, 1'b0, es.crc_error, es.overrun,
                               1'b0, es.non_dma_select_or_sector_missing,
                               es.write_protected_hit,
                               es.missing_mark || es.missing_data_mark};
    wire logic [7:0] rw_st2 = {1'b0, es.deleted_mark_seen, es.data_field_crc_error,
                               es.wrong_cylinder, es.scan_equal_hit, es.scan_unsatisfied,
                               es.bad_cylinder && es.wrong_cylinder,
                               es.missing_data_mark};
    wire logic [7:0] drive_word = {drive_lines.drive_fault, drive_lines.write_prot,
                                   drive_lines.ready, drive_lines.track_zero_line,
                                   drive_lines.two_sided_line, sel_head, sel_drive};
    wire logic enter_result = bad_cmd || do_sense || do_drive || rw_refused || rw_end;
    wire logic int_set = ready_evt || seek_evt || (xfer_byte && non_dma_mode)
                         || rw_end || rw_refused;
    wire logic int_clr = do_sense || xfer_ack || (result_read && state == fsc_pkg::ST_RESULT);
    wire logic next_int = int_set || (int_out && !int_clr);

    always_comb begin
        next_state = state;
        unique case (state)
            fsc_pkg::ST_IDLE: begin
                if (enter_result) begin
                    next_state = fsc_pkg::ST_RESULT;
                end else if (do_recal) begin
                    next_state = fsc_pkg::ST_RECAL;
                end else if (do_rw) begin
                    next_state = fsc_pkg::ST_EXEC;
                end
            end
            fsc_pkg::ST_EXEC: begin
                if (exec_done) begin
                    next_state = fsc_pkg::ST_RESULT;
                end
            end
            fsc_pkg::ST_RECAL: begin
                if (recal_fin) begin
                    next_state = fsc_pkg::ST_IDLE;
                end
            end
            fsc_pkg::ST_RESULT: begin
                if (result_read) begin
                    next_state = fsc_pkg::ST_IDLE;
                end
            end
            default: next_state = fsc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fsc_pkg::ST_IDLE;
            pre_count <= '0;
            ready_prev <= 4'h0;
            int_out <= 1'b0;
            pend_seek <= 1'b0;
            pend_ready <= 1'b0;
            seek_st0 <= `FSC_ST0_RESET;
            ready_st0 <= `FSC_ST0_RESET;
            recal_steps <= 7'h0;
            ready_lost <= 1'b0;
            ready_armed <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            ready_armed <= 1'b1;
            pre_count <= ms_tick ? '0 : pre_count + 1'b1;
            ready_prev <= ready_lines;
            int_out <= next_int;
            // A new event in the clearing cycle keeps its pending flag set.
            pend_seek <= seek_evt || (pend_seek && !do_sense);
            pend_ready <= ready_evt || (pend_ready && !(do_sense && !pend_seek));
            if (seek_evt) begin
                seek_st0 <= seek_word;
            end
            if (ready_evt) begin
                ready_st0 <= ready_word;
            end
            recal_steps <= do_recal ? 7'h0 : (in_recal && step_pulse) ? recal_steps + 7'h1
                                                                      : recal_steps;
            ready_lost <= in_exec && (ready_lost || ready_evt) && !exec_done;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            command_status_zero <= `FSC_ST0_RESET;
            command_status_one <= 8'h00;
            command_status_two <= 8'h00;
            drive_line_status <= 8'h00;
            sel_drive <= 2'h0;
            sel_head <= 1'b0;
            step_code <= 4'h0;
            unload_code <= 4'h0;
            settle_code <= 7'h0;
            non_dma_mode <= 1'b0;
        end else if (clk_en) begin
            if (bad_cmd) begin
                command_status_zero <= `FSC_ST0_INVALID;
            end else if (do_sense) begin
                command_status_zero <= sense_word;
            end else if (rw_refused) begin
                command_status_zero <= mk_st0(`FSC_TC_FAILED, 1'b0, 1'b0, 1'b1,
                                              cmd.head, cmd.drive);
            end else if (rw_end) begin
                command_status_zero <= rw_st0;
            end
            if (rw_end) begin
                command_status_one <= rw_st1;
                command_status_two <= rw_st2;
            end
            if (do_drive) begin
                drive_line_status <= {drive_word[7:3], cmd.head, cmd.drive};
            end
            if (do_drive || do_seek || do_recal || do_rw) begin
                sel_drive <= cmd.drive;
                sel_head <= cmd.head;
            end
            if (do_spec) begin
                step_code <= cmd.arg1[7:4];
                unload_code <= cmd.arg1[3:0];
                settle_code <= cmd.arg2[7:1];
                non_dma_mode <= cmd.arg2[0];
            end
        end
    end

    // The result phase is shown with direction and request both high.
    assign transfer_direction = (state == fsc_pkg::ST_RESULT);
    assign request_for_master = !in_exec && !in_recal;

    assign tmr_start[0] = rw_end;
    assign tmr_load[0] = {1'b0, unload_code, 4'h0};
    assign tmr_start[1] = step_pulse;
    assign tmr_load[1] = {4'h0, `FSC_STEP_CODE_SPAN - {1'b0, step_code}};
    assign tmr_start[2] = head_load_rise;
    assign tmr_load[2] = {1'b0, settle_code, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_tmr
            fsc_timer #(.W(9)) u_tmr (
                .mclk(mclk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .ms_tick(ms_tick),
                .start(tmr_start[gi]),
                .load(tmr_load[gi]),
                .busy(tmr_busy[gi]),
                .done(tmr_done[gi])
            );
        end
    endgenerate

    assign head_unload_due = tmr_done[0];
    assign step_ready = !tmr_busy[1];
    assign head_settled = tmr_done[2];

    a_invalid_no_int: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && bad_cmd && !int_out && !int_set) |=> !int_out && transfer_direction
        && request_for_master && command_status_zero == 8'h80)
        else $error("invalid command result wrong");
    a_sense_drops_int: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && do_sense && !int_set) |=> !int_out)
        else $error("cause query left interrupt up");
    a_seek_raises: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && seek_evt) |=> int_out && pend_seek && seek_st0[5])
        else $error("seek end lost");
    a_ready_code: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && ready_evt && !seek_evt) |=> ready_st0[7:5] == 3'b110)
        else $error("ready change code wrong");
    a_unread_seek: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && take && pend_seek && cmd.op == fsc_pkg::OP_SEEK) |=>
        command_status_zero == 8'h80 && transfer_direction)
        else $error("command after unread seek accepted");
    a_recal_limit: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && recal_limit && !recal_ok) |=> seek_st0[7:4] == 4'b0111
        && state == fsc_pkg::ST_IDLE)
        else $error("recalibrate limit not flagged");
    a_rw_result_int: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && rw_end) |=> int_out && transfer_direction && command_status_one[6] == 1'b0
        && command_status_one[3] == 1'b0 && command_status_two[7] == 1'b0)
        else $error("result entry wrong");
    a_step_inverted: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && step_pulse) |=> g_tmr[1].u_tmr.count == 9'(16 - $past(step_code)))
        else $error("step interval load wrong");
    a_nondma_int: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && xfer_byte && non_dma_mode) |=> int_out)
        else $error("non-DMA byte raised no interrupt");
    a_mode_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && do_spec) |=> non_dma_mode == $past(cmd.arg2[0]))
        else $error("transfer mode not taken");
    c_seek_query: cover property (@(posedge mclk) disable iff (!rst_n) seek_evt ##[1:20] do_sense);
    c_recal_fail: cover property (@(posedge mclk) disable iff (!rst_n) recal_limit);
    c_rw_done: cover property (@(posedge mclk) disable iff (!rst_n) rw_end ##[1:20] result_read);
    c_invalid: cover property (@(posedge mclk) disable iff (!rst_n) bad_cmd);
endmodule : fsc_core

// *** testbench/fsc_drive_model.sv ***
// Behavioural disk drive: head position, track zero and status lines.
`timescale 1ns/1ps
module fsc_drive_model #(
    parameter int START_CYL = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load_pos,
    input wire logic step_pulse,
    input wire logic stuck,
    input wire logic [3:0] lines_in,
    output fsc_pkg::fsc_lines_type drive_lines
);
    logic [6:0] cyl;
    // A stuck head never reaches track zero, so the step limit can be reached.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cyl <= 7'h00;
        end else if (load_pos) begin
            cyl <= START_CYL[6:0];
        end else if (step_pulse && !stuck && cyl != 7'h00) begin
            cyl <= cyl - 7'h01;
        end
    end
    assign drive_lines = {lines_in[3:1], cyl == 7'h00, lines_in[0]};
endmodule : fsc_drive_model

// *** testbench/fsc_core_tb.sv ***
// Self-checking bench of the status and timer block.
`timescale 1ns/1ps
module fsc_core_tb;
    localparam int MS = 4;
    logic mclk, rst_n, slow_clock_mode, cmd_strobe, result_read, step_pulse, seek_end;
    logic seek_abnormal, exec_done, xfer_byte, xfer_ack, head_load_rise, stuck;
    logic int_out, transfer_direction, request_for_master, non_dma_mode, sel_head;
    logic step_ready, head_unload_due, head_settled;
    logic [3:0] ready_lines, lines_in;
    logic [7:0] st0, st1, st2, st3;
    logic [1:0] sel_drive;
    fsc_pkg::fsc_cmd_type cmd;
    fsc_pkg::fsc_exec_type exec_status;
    fsc_pkg::fsc_lines_type drive_lines;
    int err_count, n_tests, cyc, steps, p;
    logic [15:0] ev [2] = '{16'h7a57, 16'h05aa};
    logic [7:0] ex [2][3] = '{'{8'h56, 8'ha5, 8'h57}, '{8'hc6, 8'h13, 8'h28}};

    fsc_core #(.MS_CYCLES(MS)) fsc_core_i (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
        .slow_clock_mode(slow_clock_mode), .cmd_strobe(cmd_strobe), .cmd(cmd),
        .result_read(result_read), .drive_lines(drive_lines), .ready_lines(ready_lines),
        .step_pulse(step_pulse), .seek_end(seek_end), .seek_abnormal(seek_abnormal),
        .exec_done(exec_done), .exec_status(exec_status), .xfer_byte(xfer_byte),
        .xfer_ack(xfer_ack), .head_load_rise(head_load_rise), .int_out(int_out),
        .transfer_direction(transfer_direction), .request_for_master(request_for_master),
        .non_dma_mode(non_dma_mode), .command_status_zero(st0), .command_status_one(st1),
        .command_status_two(st2), .drive_line_status(st3), .sel_drive(sel_drive),
        .sel_head(sel_head), .step_ready(step_ready), .head_unload_due(head_unload_due),
        .head_settled(head_settled));
    fsc_drive_model fsc_drive_model_i (.mclk(mclk), .rst_n(rst_n),
        .load_pos(cmd_strobe && cmd.op == fsc_pkg::OP_RECAL), .step_pulse(step_pulse),
        .stuck(stuck), .lines_in(lines_in), .drive_lines(drive_lines));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Timer phases against the prescaler are unknown, so a window is accepted.
    task automatic chk_span(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_span
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cycles
    task automatic issue(input fsc_pkg::fsc_op_type op, input logic [1:0] drv,
                         input logic hd, input logic [7:0] a1, input logic [7:0] a2);
        cycles(1);
        cmd_strobe = 1'b1;
        cmd = '{op, drv, hd, a1, a2};
        cycles(1);
        cmd_strobe = 1'b0;
        cycles(1);
    endtask : issue
    task automatic res();
        cycles(1);
        result_read = 1'b1;
        cycles(1);
        result_read = 1'b0;
    endtask : res
    task automatic recal(input logic stk);
        stuck = stk;
        issue(fsc_pkg::OP_RECAL, 2'h1, 1'b0, 8'h00, 8'h00);
        steps = 0;
        while (int_out !== 1'b1 && steps < 90) begin
            step_pulse = 1'b1;
            cycles(1);
            step_pulse = 1'b0;
            steps++;
            cycles(2);
        end
        issue(fsc_pkg::OP_SENSE_INT, 2'h0, 1'b0, 8'h00, 8'h00);
    endtask : recal
    task automatic seek(input logic abn);
        issue(fsc_pkg::OP_SEEK, 2'h3, 1'b0, 8'h00, 8'h00);
        seek_abnormal = abn;
        seek_end = 1'b1;
        cycles(1);
        seek_end = 1'b0;
        cycles(1);
    endtask : seek
    task automatic wait_for(input int which);
        cyc = 0;
        do begin
            cycles(1);
            cyc++;
        end while (cyc < 2000 && !(which == 0 ? step_ready : which == 1 ? head_settled
                                                                        : head_unload_due));
    endtask : wait_for
    task automatic final_report();
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #300000;
        err_count++;
        final_report();
    end

    initial begin
        {rst_n, slow_clock_mode, cmd_strobe, result_read, step_pulse, seek_end} = 6'h00;
        {seek_abnormal, exec_done, xfer_byte, xfer_ack, head_load_rise, stuck} = 6'h00;
        cmd = '0;
        exec_status = '0;
        ready_lines = 4'hf;
        lines_in = 4'h3;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk(st0, 8'h00);
        chk(request_for_master, 1'b1);
        issue(fsc_pkg::OP_INVALID, 2'h0, 1'b0, 8'h00, 8'h00);
        chk(st0, 8'h80);
        chk({transfer_direction, request_for_master, int_out}, 3'h6);
        res();
        foreach (ev[i]) begin
            lines_in = i ? 4'hb : 4'h6;
            issue(fsc_pkg::OP_SENSE_DRIVE, 2'h2, 1'b1, 8'h00, 8'h00);
            chk(st3, {lines_in[3:1], 1'b1, lines_in[0], 3'h6});
            res();
        end
        lines_in = 4'h3;
        recal(1'b0);
        chk(steps[7:0], 8'h03);
        chk(st0, 8'h21);
        chk(int_out, 1'b0);
        res();
        recal(1'b1);
        chk(steps[7:0], 8'h4d);
        chk(st0, 8'h71);
        res();
        seek(1'b0);
        chk(int_out, 1'b1);
        issue(fsc_pkg::OP_SENSE_DRIVE, 2'h0, 1'b0, 8'h00, 8'h00);
        chk(st0, 8'h80);
        res();
        issue(fsc_pkg::OP_SENSE_INT, 2'h0, 1'b0, 8'h00, 8'h00);
        res();
        for (int i = 0; i < 2; i++) begin
            seek(i[0]);
            issue(fsc_pkg::OP_SENSE_INT, 2'h0, 1'b0, 8'h00, 8'h00);
            chk(st0, i ? 8'h63 : 8'h23);
            res();
        end
        ready_lines = 4'hb;
        cycles(2);
        chk(int_out, 1'b1);
        issue(fsc_pkg::OP_SENSE_INT, 2'h0, 1'b0, 8'h00, 8'h00);
        chk(st0, 8'hc2);
        chk(int_out, 1'b0);
        res();
        lines_in = 4'h1;
        issue(fsc_pkg::OP_RW, 2'h0, 1'b0, 8'h00, 8'h00);
        chk(st0, 8'h48);
        chk(int_out, 1'b1);
        res();
        lines_in = 4'h2;
        issue(fsc_pkg::OP_RW, 2'h3, 1'b1, 8'h00, 8'h00);
        chk(st0, 8'h4f);
        res();
        lines_in = 4'h3;
        foreach (ev[i]) begin
            issue(fsc_pkg::OP_SPECIFY, 2'h0, 1'b0, 8'hd1, {7'h02, i == 0});
            chk(non_dma_mode, i == 0);
            issue(fsc_pkg::OP_RW, 2'h2, 1'b1, 8'h00, 8'h00);
            chk(request_for_master, 1'b0);
            chk({sel_head, sel_drive}, 8'h06);
            xfer_byte = 1'b1;
            cycles(1);
            xfer_byte = 1'b0;
            cycles(1);
            chk(int_out, i == 0);
            // The second transfer sees drive 2's ready line rise mid-execution, which must end it with code 11.
            ready_lines = i ? 4'hf : 4'hb;
            xfer_ack = 1'b1;
            cycles(1);
            xfer_ack = 1'b0;
            exec_status = ev[i];
            exec_done = 1'b1;
            cycles(1);
            exec_done = 1'b0;
            cycles(1);
            chk(st0, ex[i][0]);
            chk(st1, ex[i][1]);
            chk(st2, ex[i][2]);
            chk(int_out, 1'b1);
            wait_for(2);
            chk_span(cyc, 15 * MS - 2, 16 * MS + 3);
            res();
        end
        for (int s = 0; s < 2; s++) begin
            slow_clock_mode = s[0];
            p = MS * (1 + s);
            step_pulse = 1'b1;
            cycles(1);
            step_pulse = 1'b0;
            wait_for(0);
            chk_span(cyc, 2 * p, 3 * p + 3);
            head_load_rise = 1'b1;
            cycles(1);
            head_load_rise = 1'b0;
            wait_for(1);
            chk_span(cyc, 3 * p, 4 * p + 3);
        end
        final_report();
    end
endmodule : fsc_core_tb
